// ==== rtl/odc_consts.vh ====
`ifndef ODC_CONSTS_VH
`define ODC_CONSTS_VH
// Register offsets
`define ODC_ADDR_OUTDIV     8'h24
`define ODC_ADDR_OUTCTL4    8'h25
`define ODC_ADDR_STATUS     8'h26
// Reset values
`define ODC_RST_OUTDIV      8'h03
`define ODC_RST_OUTCTL4     8'h18
// Field positions in output_control_ch4
`define ODC_SRC_HI          7
`define ODC_SRC_LO          6
`define ODC_FMT_HI          5
`define ODC_FMT_LO          4
`define ODC_SA_HI           3
`define ODC_SA_LO           2
`define ODC_SB_HI           1
`define ODC_SB_LO           0
// Source codes
`define ODC_SRC_PLL         2'h0
`define ODC_SRC_RSVD        2'h1
`define ODC_SRC_PRI         2'h2
`define ODC_SRC_SEC         2'h3
// Format codes
`define ODC_FMT_OFF         2'h0
`define ODC_FMT_DIFF        2'h1
`define ODC_FMT_HCSL        2'h2
`define ODC_FMT_CMOS        2'h3
// Tail current in mA
`define ODC_MA_4            5'h04
`define ODC_MA_6            5'h06
`define ODC_MA_8            5'h08
`define ODC_MA_16           5'h10
// Load resistance in ohms
`define ODC_OHM_50          8'h32
`define ODC_OHM_100         8'h64
`define ODC_OHM_200         8'hC8
`endif

// ==== rtl/odc_output_ctl.v ====
// Decided for this implementation: the strobed register port.
`include "odc_consts.vh"
module odc_output_ctl (
  input  wire       mclk_i,         // 10 MHz clock
  input  wire       reset_i,        // Sync reset, active high
  input  wire [7:0] addr_i,         // Register address
  input  wire [7:0] wdata_i,        // Write data
  input  wire       wr_i,           // Write strobe
  input  wire       rd_i,           // Read strobe
  input  wire       doubler_en_i,   // Reference doubler enabled
  output reg  [7:0] rdata_o,        // Read data, cycle after strobe
  output reg  [8:0] ch23_ratio_o,   // Divide ratio, channels 2 and 3
  output reg  [8:0] ch4_ratio_o,    // Effective ratio on channel 4 path
  output reg  [1:0] ch4_src_o,      // 0 PLL, 1 primary, 2 secondary, 3 none
  output reg        ch4_bypass_o,   // Output divider bypassed
  output reg        ch4_doubled_o,  // Doubled reference delivered
  output reg  [1:0] ch4_fmt_o,      // Active driver format
  output reg  [4:0] ch4_tail_ma_o,  // Tail current in mA
  output reg  [7:0] ch4_rload_o,    // HCSL load in ohms, 0 tristate
  output reg  [2:0] ch4_pin_p_o,    // Positive pin: power, drive, invert
  output reg  [2:0] ch4_pin_n_o     // Negative pin: power, drive, invert
);

  reg  [7:0] shared_output_divider_ch2_ch3;
  reg  [7:0] output_control_ch4;
  reg        doubler_s1;
  reg        doubler_s2;

  wire [1:0] chan4_source_select;
  wire [1:0] chan4_format;
  wire [1:0] chan4_driver_setting_a;
  wire [1:0] chan4_driver_setting_b;
  wire       cmos_fmt;
  wire [2:0] pin_p;
  wire [2:0] pin_n;
  wire [8:0] div_ratio;

  reg  [4:0] next_tail;
  reg  [7:0] next_rload;
  reg  [1:0] next_src;
  reg        next_bypass;

  assign chan4_source_select    = output_control_ch4[`ODC_SRC_HI:`ODC_SRC_LO];
  assign chan4_format           = output_control_ch4[`ODC_FMT_HI:`ODC_FMT_LO];
  assign chan4_driver_setting_a = output_control_ch4[`ODC_SA_HI:`ODC_SA_LO];
  assign chan4_driver_setting_b = output_control_ch4[`ODC_SB_HI:`ODC_SB_LO];
  assign cmos_fmt               = (chan4_format == `ODC_FMT_CMOS);
  // Ratio is code plus one, widened so 0xFF gives 256
  assign div_ratio = {1'b0, shared_output_divider_ch2_ch3} + 9'h001;

  // Register writes; doubler pin crosses in through two flops
  always @(posedge mclk_i) begin
    if (reset_i) begin
      shared_output_divider_ch2_ch3 <= `ODC_RST_OUTDIV;
      output_control_ch4            <= `ODC_RST_OUTCTL4;
      doubler_s1                    <= 1'b0;
      doubler_s2                    <= 1'b0;
    end else begin
      doubler_s1 <= doubler_en_i;
      doubler_s2 <= doubler_s1;
      if (wr_i && addr_i == `ODC_ADDR_OUTDIV) begin
        shared_output_divider_ch2_ch3 <= wdata_i;
      end
      if (wr_i && addr_i == `ODC_ADDR_OUTCTL4) begin
        output_control_ch4 <= wdata_i;
      end
    end
  end

  // Read mux; unmapped addresses return zero
  always @(posedge mclk_i) begin
    if (reset_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        `ODC_ADDR_OUTDIV:  rdata_o <= shared_output_divider_ch2_ch3;
        `ODC_ADDR_OUTCTL4: rdata_o <= output_control_ch4;
        `ODC_ADDR_STATUS:  rdata_o <= {5'h00, ch4_doubled_o, ch4_bypass_o,
                                       (chan4_source_select == `ODC_SRC_RSVD)};
        default:           rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // Source decode; reserved code leaves channel without source
  always @* begin
    next_src    = 2'h3;
    next_bypass = 1'b0;
    case (chan4_source_select)
      `ODC_SRC_PLL: begin
        next_src = 2'h0;
      end
      `ODC_SRC_PRI: begin
        next_src    = 2'h1;
        next_bypass = 1'b1;
      end
      `ODC_SRC_SEC: begin
        next_src    = 2'h2;
        next_bypass = 1'b1;
      end
      default: begin
        next_src    = 2'h3;
        next_bypass = 1'b0;
      end
    endcase
  end

  // Driver strength decode by format
  always @* begin
    next_tail  = 5'h00;
    next_rload = 8'h00;
    if (chan4_format == `ODC_FMT_DIFF || chan4_format == `ODC_FMT_HCSL) begin
      case (chan4_driver_setting_a)
        2'h0:    next_tail = `ODC_MA_4;
        2'h1:    next_tail = `ODC_MA_6;
        2'h2:    next_tail = `ODC_MA_8;
        default: next_tail = (chan4_format == `ODC_FMT_HCSL) ? `ODC_MA_16 : `ODC_MA_8;
      endcase
    end
    if (chan4_format == `ODC_FMT_HCSL) begin
      case (chan4_driver_setting_b)
        2'h1:    next_rload = `ODC_OHM_50;
        2'h2:    next_rload = `ODC_OHM_100;
        2'h3:    next_rload = `ODC_OHM_200;
        default: next_rload = 8'h00;
      endcase
    end
  end

  // Per-pin decode shared by both single-ended pins
  odc_pin_ctl u_pin_p (
    .code_i   (chan4_driver_setting_a),
    .cmos_i   (cmos_fmt),
    .power_o  (pin_p[2]),
    .drive_o  (pin_p[1]),
    .invert_o (pin_p[0])
  );

  odc_pin_ctl u_pin_n (
    .code_i   (chan4_driver_setting_b),
    .cmos_i   (cmos_fmt),
    .power_o  (pin_n[2]),
    .drive_o  (pin_n[1]),
    .invert_o (pin_n[0])
  );

  // Registered outputs, one cycle after a register write
  always @(posedge mclk_i) begin
    if (reset_i) begin
      ch23_ratio_o  <= 9'h000;
      ch4_ratio_o   <= 9'h000;
      ch4_src_o     <= 2'h0;
      ch4_bypass_o  <= 1'b0;
      ch4_doubled_o <= 1'b0;
      ch4_fmt_o     <= `ODC_FMT_OFF;
      ch4_tail_ma_o <= 5'h00;
      ch4_rload_o   <= 8'h00;
      ch4_pin_p_o   <= 3'h0;
      ch4_pin_n_o   <= 3'h0;
    end else begin
      ch23_ratio_o  <= div_ratio;
      // Reference path skips divider, ratio reads as one
      ch4_ratio_o   <= next_bypass ? 9'h001 : div_ratio;
      ch4_src_o     <= next_src;
      ch4_bypass_o  <= next_bypass;
      ch4_doubled_o <= next_bypass & doubler_s2;
      ch4_fmt_o     <= chan4_format;
      ch4_tail_ma_o <= next_tail;
      ch4_rload_o   <= next_rload;
      ch4_pin_p_o   <= pin_p;
      ch4_pin_n_o   <= pin_n;
    end
  end

endmodule // odc_output_ctl

// ==== rtl/odc_pin_ctl.v ====
`include "odc_consts.vh"
// Decodes one single-ended pin setting
module odc_pin_ctl (
  input  wire [1:0] code_i,   // Pin setting code
  input  wire       cmos_i,   // Single-ended format active
  output wire       power_o,  // Pin powered up
  output wire       drive_o,  // Pin actively driven
  output wire       invert_o  // Negative polarity
);
  // Non-single-ended formats leave pins off here
  assign power_o  = cmos_i & code_i[1];
  assign drive_o  = cmos_i & (code_i != 2'h0);
  assign invert_o = cmos_i & (code_i == 2'h2);
endmodule // odc_pin_ctl

// ==== verif/odc_output_ctl_props.sv ====
module odc_output_ctl_props (
  input wire       mclk_i,        // Clock
  input wire       reset_i,       // Reset
  input wire [7:0] addr_i,        // Address
  input wire [7:0] wdata_i,       // Write data
  input wire       wr_i,          // Write
  input wire       rd_i,          // Read
  input wire [7:0] rdata_o,       // Read data
  input wire [8:0] ch23_ratio_o,  // Shared ratio
  input wire [8:0] ch4_ratio_o,   // Ch4 ratio
  input wire       ch4_bypass_o,  // Bypass
  input wire       ch4_doubled_o, // Doubled
  input wire [1:0] ch4_fmt_o,     // Format
  input wire [4:0] ch4_tail_ma_o, // Tail mA
  input wire [2:0] ch4_pin_p_o    // Positive pin
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  // Writes reach the derived outputs two edges after the strobe
  sequence s_wr24; wr_i && addr_i == 8'h24; endsequence
  sequence s_wr25; wr_i && addr_i == 8'h25; endsequence
  property p_div; s_wr24 |-> ##2 ch23_ratio_o == {1'b0, $past(wdata_i, 2)} + 9'h001; endproperty
  a_div: assert property (p_div) else $error("shared ratio wrong");
  property p_byp; s_wr25 |-> ##2 ch4_bypass_o == $past(wdata_i[7], 2); endproperty
  a_byp: assert property (p_byp) else $error("bypass wrong");
  property p_fmt; s_wr25 |-> ##2 ch4_fmt_o == $past(wdata_i[5:4], 2); endproperty
  a_fmt: assert property (p_fmt) else $error("format wrong");
  // Static relations between outputs
  property p_one; ch4_bypass_o |-> ch4_ratio_o == 9'h001; endproperty
  a_one: assert property (p_one) else $error("bypassed ratio not 1");
  property p_dbl; ch4_doubled_o |-> ch4_bypass_o; endproperty
  a_dbl: assert property (p_dbl) else $error("doubled without reference");
  property p_tail; (ch4_tail_ma_o != 5'h00) == (ch4_fmt_o[1] != ch4_fmt_o[0]); endproperty
  a_tail: assert property (p_tail) else $error("tail current format mismatch");
  property p_pin; ch4_fmt_o != 2'h3 |-> ch4_pin_p_o == 3'h0; endproperty
  a_pin: assert property (p_pin) else $error("pin active outside LVCMOS");
  // Read data stands one cycle only
  property p_rd; rd_i && addr_i == 8'h24 |=> rdata_o == ch23_ratio_o[7:0] - 8'h01; endproperty
  a_rd: assert property (p_rd) else $error("divider read back wrong");
  property p_idle; !rd_i |=> rdata_o == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("read data without strobe");
endmodule // odc_output_ctl_props
bind odc_output_ctl odc_output_ctl_props u_odc_output_ctl_props (.mclk_i(mclk_i),
  .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .ch23_ratio_o(ch23_ratio_o), .ch4_ratio_o(ch4_ratio_o),
  .ch4_bypass_o(ch4_bypass_o), .ch4_doubled_o(ch4_doubled_o), .ch4_fmt_o(ch4_fmt_o),
  .ch4_tail_ma_o(ch4_tail_ma_o), .ch4_pin_p_o(ch4_pin_p_o));

// ==== verif/tb_odc_output_ctl.sv ====
module tb_odc_output_ctl;
  timeunit 1ns;
  timeprecision 1ns;
  logic       mclk_i       = 1'b0;
  logic       reset_i      = 1'b1;
  logic [7:0] addr_i       = 8'h00;
  logic [7:0] wdata_i      = 8'h00;
  logic       wr_i         = 1'b0;
  logic       rd_i         = 1'b0;
  logic       doubler_en_i = 1'b0;
  wire  [7:0] rdata_o, ch4_rload_o;
  wire  [8:0] ch23_ratio_o, ch4_ratio_o;
  wire  [1:0] ch4_src_o, ch4_fmt_o;
  wire        ch4_bypass_o, ch4_doubled_o;
  wire  [4:0] ch4_tail_ma_o;
  wire  [2:0] ch4_pin_p_o, ch4_pin_n_o;
  int         miscompares  = 0;
  int         n_checks     = 0;
  logic [1:0] src_map [4]  = '{2'h0, 2'h3, 2'h1, 2'h2};
  logic [7:0] divs [3]     = '{8'h00, 8'h01, 8'hFF};
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD %s exp %0h got %0h", n, e, g); end end
  odc_output_ctl u_odc_output_ctl (.mclk_i(mclk_i), .reset_i(reset_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .doubler_en_i(doubler_en_i),
    .rdata_o(rdata_o), .ch23_ratio_o(ch23_ratio_o), .ch4_ratio_o(ch4_ratio_o),
    .ch4_src_o(ch4_src_o), .ch4_bypass_o(ch4_bypass_o), .ch4_doubled_o(ch4_doubled_o),
    .ch4_fmt_o(ch4_fmt_o), .ch4_tail_ma_o(ch4_tail_ma_o), .ch4_rload_o(ch4_rload_o),
    .ch4_pin_p_o(ch4_pin_p_o), .ch4_pin_n_o(ch4_pin_n_o));
  // Free-running 10 MHz clock
  initial forever #50 mclk_i = ~mclk_i;
  // Expected tail current, zero outside the differential formats
  function automatic logic [4:0] tail_of(input logic [5:0] c);
    if (c[5] == c[4]) return 5'h00;
    if (c[3:2] != 2'h3) return 5'h04 + {2'h0, c[3:2], 1'b0};
    return c[5] ? 5'h10 : 5'h08;
  endfunction
  // Expected single-ended pin state as power, drive, invert
  function automatic logic [2:0] pin_of(input logic [1:0] f, input logic [1:0] k);
    return (f == 2'h3) ? {k[1], |k, k == 2'h2} : 3'h0;
  endfunction
  // Write, then wait until derived outputs have settled
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
  endtask
  // Read data is looked at in its single valid cycle
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    // Mid-cycle, while the data launched at the strobe edge still stand
    @(negedge mclk_i);
    `CHK("rdata", e, rdata_o)
    @(posedge mclk_i);
  endtask
  task automatic end_sim();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Guard against a hang, far beyond the expected run length
  initial begin
    #5000000 miscompares++;
    end_sim();
  end
  // Main sequence
  initial begin
    logic [5:0] c;
    repeat (8) @(posedge mclk_i);
    reset_i <= 1'b0;
    @(posedge mclk_i);
    rd(8'h24, 8'h03);
    rd(8'h25, 8'h18);
    `CHK("ratio23", 9'h004, ch23_ratio_o)
    `CHK("tail", 5'h08, ch4_tail_ma_o)
    $display("test reset done");
    for (int i = 0; i < 3; i++) begin
      wr(8'h24, divs[i]);
      `CHK("ratio23", {1'b0, divs[i]} + 9'h001, ch23_ratio_o)
      rd(8'h24, divs[i]);
    end
    wr(8'h26, 8'h00);
    wr(8'h30, 8'h00);
    rd(8'h30, 8'h00);
    rd(8'h24, 8'hFF);
    $display("test divider done");
    doubler_en_i <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      c = 6'(s);
      wr(8'h25, {c[1:0], 6'h18});
      `CHK("src", src_map[s], ch4_src_o)
      `CHK("bypass", c[1], ch4_bypass_o)
      `CHK("doubled", c[1], ch4_doubled_o)
      if (c[1]) `CHK("ratio4", 9'h001, ch4_ratio_o)
      else `CHK("ratio4", 9'h100, ch4_ratio_o)
      rd(8'h26, {5'h00, c[1], c[1], c[1:0] == 2'h1});
    end
    doubler_en_i <= 1'b0;
    repeat (5) @(posedge mclk_i);
    `CHK("doubled", 1'b0, ch4_doubled_o)
    $display("test source done");
    for (int i = 0; i < 64; i++) begin
      c = 6'(i);
      wr(8'h25, {2'h0, c});
      `CHK("fmt", c[5:4], ch4_fmt_o)
      `CHK("tail", tail_of(c), ch4_tail_ma_o)
      `CHK("rload", (c[5:4] == 2'h2 && c[1:0] != 2'h0) ? 8'h19 << c[1:0] : 8'h00, ch4_rload_o)
      `CHK("pin_p", pin_of(c[5:4], c[3:2]), ch4_pin_p_o)
      `CHK("pin_n", pin_of(c[5:4], c[1:0]), ch4_pin_n_o)
    end
    rd(8'h25, 8'h3F);
    $display("test format done");
    end_sim();
  end
endmodule // tb_odc_output_ctl
